// ---- shared/tphz_regs.svh ----
`ifndef TPHZ_REGS_SVH
`define TPHZ_REGS_SVH
// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define TPHZ_ADDR_W        4
`define TPHZ_OFS_SWREQ     4'h0
`define TPHZ_OFS_PINEN     4'h1
`define TPHZ_OFS_STATUS    4'h2
`define TPHZ_SWREQ_RST     8'h00
`define TPHZ_PINEN_RST     8'h00
`define TPHZ_BIT_HC        0
`define TPHZ_BIT_CH0       1
`define TPHZ_PINEN_MASK    8'h0f
`endif

// ---- shared/tphz_pkg.sv ----
`default_nettype none
// ----------------------------------------
// Types of the timer pin float control
// ----------------------------------------
package tphz_pkg;
  typedef logic [7:0] tphz_byte_t;
  typedef logic [3:0] tphz_addr_t;
  typedef logic [3:0] tphz_pins_t;
endpackage
`default_nettype wire

// ---- rtl/tphz_sync.sv ----
`include "tphz_regs.svh"
`default_nettype none
// ----------------------------------------
// Two-stage synchroniser for the external request flag
// ----------------------------------------
module tphz_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level in and out
  input  wire logic din,
  output var  logic dout
);
  import tphz_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
  } tphz_sync_st_t;

  tphz_sync_st_t st_q;
  tphz_sync_st_t st_d;

  // Next state: first stage feeds only the second
  always_comb begin
    st_d    = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.s2;
endmodule
`default_nettype wire

// ---- rtl/tphz_ctrl.sv ----
// Chosen here: the register offsets and the strobed register port.
`include "tphz_regs.svh"
`default_nettype none
module tphz_ctrl (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Register port
  input  wire tphz_pkg::tphz_addr_t addr,
  input  wire tphz_pkg::tphz_byte_t wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output var  tphz_pkg::tphz_byte_t rdata,
  // External request flag level
  input  wire logic             external_request_flag,
  // Float controls toward the pins
  output var  tphz_pkg::tphz_pins_t chan0_pin_float,
  output var  logic             high_current_float_request
);
  import tphz_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic       ch0_req;
    logic       hc_req;
    logic       ch0_seen;
    logic       hc_seen;
    tphz_pins_t pin_en;
    logic       pin_en_locked;
    tphz_byte_t rdata;
    tphz_pins_t pin_float;
    logic       hc_out;
  } tphz_st_t;

  tphz_st_t st_q;
  tphz_st_t st_d;
  logic     ext_flag_s;

  // Flag synchroniser, as it comes from a foreign domain
  tphz_sync u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (external_request_flag),
    .dout (ext_flag_s)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Read view of the request register
  function automatic tphz_byte_t swreq_view(input logic ch0, input logic hc);
    tphz_byte_t v;
    v = 8'h00;
    v[`TPHZ_BIT_CH0] = ch0;
    v[`TPHZ_BIT_HC]  = hc;
    return v;
  endfunction

  // Per-pin float decision
  function automatic tphz_pins_t float_of(input tphz_pins_t en, input logic flag, input logic ch0);
    return en & {4{flag | ch0}};
  endfunction

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic       wr_swreq;
  logic       wr_pinen;
  logic       rd_swreq;
  logic       rd_pinen;
  logic       rd_status;
  tphz_pins_t wr_nib;
  tphz_pins_t float_w;

  // Strobes qualified by the register index
  assign wr_swreq  = wr && (addr == `TPHZ_OFS_SWREQ);
  assign wr_pinen  = wr && (addr == `TPHZ_OFS_PINEN);
  assign rd_swreq  = rd && (addr == `TPHZ_OFS_SWREQ);
  assign rd_pinen  = rd && (addr == `TPHZ_OFS_PINEN);
  assign rd_status = rd && (addr == `TPHZ_OFS_STATUS);

  // Low nibble of a write, the only enable bits that exist
  assign wr_nib = wdata[3:0];

  // ----------------------------------------
  // Float path
  // ----------------------------------------
  // Per-pin float decision, one slice per channel 0 pin
  for (genvar gi = 0; gi < 4; gi++) begin : g_pin
    assign float_w[gi] = st_q.pin_en[gi] & (ext_flag_s | st_q.ch0_req);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    // Remember a read that saw each request bit at 1
    if (rd_swreq && st_q.ch0_req) begin
      st_d.ch0_seen = 1'b1;
    end
    if (rd_swreq && st_q.hc_req) begin
      st_d.hc_seen = 1'b1;
    end
    // Request register write: set by 1, clear by 0 only after read-as-1
    if (wr_swreq) begin
      if (wdata[`TPHZ_BIT_CH0]) begin
        st_d.ch0_req = 1'b1;
      end else if (st_q.ch0_seen) begin
        st_d.ch0_req  = 1'b0;
        st_d.ch0_seen = 1'b0;
      end
      if (wdata[`TPHZ_BIT_HC]) begin
        st_d.hc_req = 1'b1;
      end else if (st_q.hc_seen) begin
        st_d.hc_req  = 1'b0;
        st_d.hc_seen = 1'b0;
      end
    end
    // Enable register: first write only, then locked
    if (wr_pinen && !st_q.pin_en_locked) begin
      st_d.pin_en        = wdata[3:0];
      st_d.pin_en_locked = 1'b1;
    end
    // Read data, one cycle after the strobe; unmapped reads return 0
    st_d.rdata = 8'h00;
    if (rd) begin
      case (addr)
        `TPHZ_OFS_SWREQ:  st_d.rdata = swreq_view(st_q.ch0_req, st_q.hc_req);
        `TPHZ_OFS_PINEN:  st_d.rdata = {4'h0, st_q.pin_en};
        `TPHZ_OFS_STATUS: st_d.rdata = {6'h00, st_q.pin_en_locked, ext_flag_s};
        default:          st_d.rdata = 8'h00;
      endcase
    end
    // Registered float outputs
    // A pin floats only while its enable and one of the two requests stand
    st_d.pin_float = float_w;
    st_d.hc_out    = st_q.hc_req;
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata                      = st_q.rdata;
  assign chan0_pin_float            = st_q.pin_float;
  assign high_current_float_request = st_q.hc_out;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);


  // Reserved request bits never show in a read
  AST_SWREQ_RSVD: assert property (rd_swreq |=> rdata[7:2] == 6'h00)
    else $error("reserved request bits read nonzero");

  // Reserved enable bits never show in a read
  AST_PINEN_RSVD: assert property (rd && addr == `TPHZ_OFS_PINEN |=> rdata[7:4] == 4'h0)
    else $error("reserved enable bits read nonzero");

  // Read data is zero in every cycle that does not follow a read
  AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");

  // A write of 1 sets the channel 0 request
  AST_CH0_SET: assert property (wr_swreq && wdata[1] |=> st_q.ch0_req)
    else $error("channel 0 request not set by write");

  // A write of 1 sets the high-current request, exported a cycle later
  AST_HC_SET: assert property (wr_swreq && wdata[0] |=> ##1 high_current_float_request)
    else $error("high-current request not exported after write");

  // Without a read of 1 the channel 0 request holds
  AST_CH0_HOLD: assert property (st_q.ch0_req && !st_q.ch0_seen && !rd_swreq |=> st_q.ch0_req)
    else $error("channel 0 request cleared without read");

  // Without a read of 1 the high-current request holds
  AST_HC_HOLD: assert property (st_q.hc_req && !st_q.hc_seen && !rd_swreq |=> st_q.hc_req)
    else $error("high-current request cleared without read");

  // A write of 0 after a read of 1 clears the channel 0 request
  AST_CH0_CLR: assert property (wr_swreq && !wdata[1] && st_q.ch0_seen |=> !st_q.ch0_req)
    else $error("channel 0 request not cleared after read");

  // A write of 0 after a read of 1 clears the high-current request
  AST_HC_CLR: assert property (wr_swreq && !wdata[0] && st_q.hc_seen |=> !st_q.hc_req)
    else $error("high-current request not cleared after read");

  // Channel 0 request shows in its bit of a read
  AST_CH0_VIEW: assert property (rd_swreq |=> rdata[1] == $past(st_q.ch0_req))
    else $error("channel 0 request read back wrong");

  // High-current request shows in its bit of a read
  AST_HC_VIEW: assert property (rd_swreq |=> rdata[0] == $past(st_q.hc_req))
    else $error("high-current request read back wrong");

  // Enables never move once locked
  AST_LOCK: assert property (st_q.pin_en_locked |=> $stable(st_q.pin_en))
    else $error("pin enables changed after lock");

  // The low nibble of the first enable write is taken
  AST_PINEN_TAKE: assert property (wr_pinen && !st_q.pin_en_locked |=> st_q.pin_en == $past(wr_nib))
    else $error("first enable write not taken");

  // Any enable write locks the register
  AST_PINEN_LOCKS: assert property (wr_pinen |=> st_q.pin_en_locked)
    else $error("enable register not locked by write");

  // Enables show in the low nibble of a read
  AST_PINEN_VIEW: assert property (rd_pinen |=> rdata[3:0] == $past(st_q.pin_en))
    else $error("enable bits read back wrong");

  // Status read shows the synchronised flag and the lock
  AST_STATUS_VIEW: assert property (rd_status |=> rdata[0] == $past(ext_flag_s))
    else $error("status flag read back wrong");
  AST_STATUS_LOCK: assert property (rd_status |=> rdata[1] == $past(st_q.pin_en_locked))
    else $error("status lock read back wrong");

  // Pin float against the reference decision
  AST_FLOAT: assert property (##1 chan0_pin_float == float_of($past(st_q.pin_en), $past(ext_flag_s),
                                                              $past(st_q.ch0_req)))
    else $error("pin float mismatch");

  // No enable, no float
  AST_PINS_IDLE: assert property (st_q.pin_en == 4'h0 |=> chan0_pin_float == 4'h0)
    else $error("pin floats without enable");

  // No request, no float
  AST_PINS_QUIET: assert property (!ext_flag_s && !st_q.ch0_req |=> chan0_pin_float == 4'h0)
    else $error("pin floats without request");

  // With all four pins enabled, every pin floats on a software request
  AST_PINS_ALL: assert property (st_q.pin_en == 4'hf && st_q.ch0_req |=> chan0_pin_float == 4'hf)
    else $error("enabled pin not floated");

  // High-current output follows its request
  AST_HC_OUT: assert property (##1 high_current_float_request == $past(st_q.hc_req))
    else $error("high-current output mismatch");

  // No high-current request, no high-current float
  AST_HC_QUIET: assert property (!st_q.hc_req |=> !high_current_float_request)
    else $error("high-current float without request");

  // ----------------------------------------
  // Coverage of the main scenarios
  // ----------------------------------------
  COV_CH0: cover property (wr_swreq && wdata[1] ##2 chan0_pin_float != 4'h0);
  COV_CLR: cover property (rd_swreq && st_q.hc_req ##1 wr_swreq && !wdata[0]);
  COV_LOCK: cover property (wr_pinen && st_q.pin_en_locked);
  COV_FLAG: cover property (ext_flag_s && !st_q.ch0_req && st_q.pin_en != 4'h0 ##1 chan0_pin_float != 4'h0);
  COV_HC: cover property (wr_swreq && wdata[0] ##2 high_current_float_request);
endmodule
`default_nettype wire

// ---- testbench/tphz_pins_model.sv ----
`default_nettype none
// ----------------------------------------
// Far side: source of the external request flag
// ----------------------------------------
module tphz_pins_model (
  // Clock and trip command
  input  wire logic clk,
  input  wire logic trip,
  // Flag toward the block
  output var  logic external_request_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  // Flag is low from power-up
  initial external_request_flag = 1'b0;
  // Flag latches on a trip and then stays set
  always @(posedge clk) if (trip) external_request_flag <= 1'b1;
endmodule
`default_nettype wire

// ---- testbench/tb_tphz_ctrl.sv ----
`include "tphz_regs.svh"
`default_nettype none
module tb_tphz_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clk = 0, rst = 1, wr = 0, rd = 0, trip = 0, flag, hc;
  tphz_pkg::tphz_addr_t addr = 4'h0;
  tphz_pkg::tphz_byte_t wdata = 8'h00, rdata, v;
  tphz_pkg::tphz_pins_t pins;
  int                   fail_count = 0, checks = 0, cyc = 0;
  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  tphz_ctrl i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .external_request_flag(flag), .chan0_pin_float(pins), .high_current_float_request(hc));
  tphz_pins_model i_far (.clk(clk), .trip(trip), .external_request_flag(flag));
  // Clock and hang guard
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1; addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 v = rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_out(input string n, input logic [3:0] e, input logic [3:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_reg(`TPHZ_OFS_SWREQ); chk("swreq", 8'h00, v);
    rd_reg(`TPHZ_OFS_PINEN); chk("pinen", 8'h00, v);
    chk_out("pins", 4'h0, pins);
  endtask
  task automatic t_request;
    wr_reg(`TPHZ_OFS_SWREQ, 8'h07);
    wr_reg(`TPHZ_OFS_SWREQ, 8'h00);
    rd_reg(`TPHZ_OFS_SWREQ); chk("swreq", 8'h03, v);
    chk_out("hc", 4'h1, {3'h0, hc});
    chk_out("pins", 4'h0, pins);
    wr_reg(`TPHZ_OFS_SWREQ, 8'h00);
    rd_reg(`TPHZ_OFS_SWREQ); chk("swreq", 8'h00, v);
    chk_out("hc", 4'h0, {3'h0, hc});
  endtask
  task automatic t_enable;
    wr_reg(`TPHZ_OFS_PINEN, 8'hfa);
    wr_reg(`TPHZ_OFS_PINEN, 8'h05);
    rd_reg(`TPHZ_OFS_PINEN); chk("pinen", 8'h0a, v);
    wr_reg(`TPHZ_OFS_SWREQ, 8'h02);
    rd_reg(`TPHZ_OFS_SWREQ); chk("swreq", 8'h02, v);
    chk_out("pins", 4'ha, pins);
    wr_reg(`TPHZ_OFS_SWREQ, 8'h00);
    rd_reg(`TPHZ_OFS_SWREQ); chk("swreq", 8'h00, v);
    chk_out("pins", 4'h0, pins);
  endtask
  task automatic t_unmapped;
    wr_reg(4'hf, 8'hff);
    rd_reg(4'hf); chk("unmapped", 8'h00, v);
    rd_reg(`TPHZ_OFS_SWREQ); chk("swreq", 8'h00, v);
  endtask
  task automatic t_flag;
    @(posedge clk);
    trip <= 1;
    @(posedge clk);
    trip <= 0;
    repeat (4) @(posedge clk);
    #1 chk_out("pins", 4'ha, pins);
    chk_out("hc", 4'h0, {3'h0, hc});
    rd_reg(`TPHZ_OFS_STATUS); chk("status", 8'h03, v);
  endtask
  // Reset in mid-run: requests clear and the enables take one write again
  task automatic t_rereset;
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    rd_reg(`TPHZ_OFS_SWREQ); chk("swreq", 8'h00, v);
    wr_reg(`TPHZ_OFS_PINEN, 8'h05);
    rd_reg(`TPHZ_OFS_PINEN); chk("pinen", 8'h05, v);
    repeat (2) @(posedge clk);
    #1 chk_out("pins", 4'h5, pins);
  endtask
  // Closing report
  task automatic give_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    t_reset();
    t_request();
    t_enable();
    t_unmapped();
    t_flag();
    t_rereset();
    give_verdict();
  end
endmodule
`default_nettype wire
